/* include/pmsm_pkg.sv */
// Register map, frame layout and types of the management serial master.
package pmsm_pkg;

  // ------------------------------------------------------------------
  // Register map, byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0]  CFG_OFS       = 8'h00;
  localparam logic [7:0]  CMD_OFS       = 8'h04;
  localparam logic [7:0]  ADR_OFS       = 8'h08;
  localparam logic [7:0]  WTD_OFS       = 8'h0C;
  localparam logic [7:0]  RDD_OFS       = 8'h10;
  localparam logic [7:0]  IND_OFS       = 8'h14;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int unsigned CFG_PREAMBLE_SUPPRESS_BIT = 1;
  localparam int unsigned CFG_DIV_LSB   = 2;
  localparam int unsigned CMD_READ_BIT  = 0;
  localparam int unsigned CMD_SCAN_BIT  = 1;
  localparam int unsigned ADR_REG_LSB   = 0;
  localparam int unsigned ADR_PHY_LSB   = 8;
  localparam int unsigned IND_BUSY_BIT  = 0;
  localparam int unsigned IND_NV_BIT    = 2;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [5:0]  CFG_RST       = 6'h00;
  localparam logic [1:0]  CMD_RST       = 2'h0;
  localparam logic [9:0]  ADR_RST       = 10'h000;
  localparam logic [15:0] DATA_RST      = 16'h0000;

  // ------------------------------------------------------------------
  // Frame layout, bit positions counted from the first preamble bit
  // ------------------------------------------------------------------
  localparam logic [31:0] PRE_PAT       = 32'hFFFF_FFFF;
  localparam logic [1:0]  START_PAT     = 2'h1;
  localparam logic [1:0]  OP_READ       = 2'h2;
  localparam logic [1:0]  OP_WRITE      = 2'h1;
  localparam logic [1:0]  TA_WRITE      = 2'h2;
  localparam logic [5:0]  POS_FULL      = 6'h00;
  localparam logic [5:0]  POS_PREAMBLE_SUPPRESS     = 6'h20;
  localparam logic [5:0]  POS_START     = 6'h20;
  localparam logic [5:0]  POS_TA        = 6'h2E;
  localparam logic [5:0]  POS_DATA      = 6'h30;
  localparam logic [5:0]  POS_LAST      = 6'h3F;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned BUSY_DELAY    = 3;
  localparam logic [5:0]  HALF_BASE_M1  = 6'h03;

  typedef struct packed
  {
    logic        rd;
    logic [4:0]  phy;
    logic [4:0]  reg_addr_field;
    logic [15:0] data;
  } pmsm_req_t;

  typedef enum logic {ST_IDLE, ST_RUN} pmsm_state_t;

endpackage

/* src/pmsm_master.sv */
// Management serial master: register port, clock divider and frame engine.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module pmsm_master
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe
);

  // ------------------------------------------------------------------
  // Register group
  // ------------------------------------------------------------------
  logic [5:0]          cfg_r,   cfg_nxt;
  logic [1:0]          cmd_r,   cmd_nxt;
  logic [9:0]          adr_r,   adr_nxt;
  logic [15:0]         wtd_r,   wtd_nxt;
  logic [1:0]          pipe_r,  pipe_nxt;
  pmsm_pkg::pmsm_req_t req_r,   req_nxt;
  logic [31:0]         rdat_r,  rdat_nxt;
  logic                trig;
  logic                trig_scan;

  // Link group state, declared here because reads look at it.
  pmsm_pkg::pmsm_state_t state_r, state_nxt;
  pmsm_pkg::pmsm_req_t   cur_r,   cur_nxt;
  logic [5:0]            pos_r,   pos_nxt;
  logic [5:0]            cnt_r,   cnt_nxt;
  logic                  mdc_r,   mdc_nxt;
  logic                  mo_r,    mo_nxt;
  logic                  oe_r,    oe_nxt;
  logic [15:0]           rx_r,    rx_nxt;
  logic [15:0]           rdd_r,   rdd_nxt;
  logic                  busy_r,  busy_nxt;
  logic                  nv_r,    nv_nxt;

  logic                  preamble_suppress;
  logic [5:0]            half_m1;
  logic                  tick;
  logic                  frame_end;
  logic [5:0]            pos_first;
  pmsm_pkg::pmsm_req_t   scan_req;

  assign preamble_suppress     = cfg_r[pmsm_pkg::CFG_PREAMBLE_SUPPRESS_BIT];
  assign pos_first = preamble_suppress ? pmsm_pkg::POS_PREAMBLE_SUPPRESS : pmsm_pkg::POS_FULL;
  assign scan_req  = '{rd: 1'b1, phy: adr_r[9:5], reg_addr_field: adr_r[4:0],
                       data: pmsm_pkg::DATA_RST};

  always_comb
  begin
    cfg_nxt   = cfg_r;
    cmd_nxt   = cmd_r;
    adr_nxt   = adr_r;
    wtd_nxt   = wtd_r;
    req_nxt   = req_r;
    rdat_nxt  = 32'h0000_0000;
    trig      = 1'b0;
    trig_scan = 1'b0;
    if (reg_wr)
    begin
      case (reg_addr)
        pmsm_pkg::CFG_OFS:
        begin
          cfg_nxt = reg_wdata[pmsm_pkg::CFG_DIV_LSB+3:0];
        end
        pmsm_pkg::CMD_OFS:
        begin
          cmd_nxt = reg_wdata[1:0];
          // read start on rising command bit
          if (reg_wdata[pmsm_pkg::CMD_READ_BIT] &&
              !cmd_r[pmsm_pkg::CMD_READ_BIT])
          begin
            trig = 1'b1;
          end
          // scan start on rising command bit
          if (reg_wdata[pmsm_pkg::CMD_SCAN_BIT] &&
              !cmd_r[pmsm_pkg::CMD_SCAN_BIT])
          begin
            trig      = 1'b1;
            trig_scan = 1'b1;
          end
          if (trig)
          begin
            req_nxt = scan_req;
          end
        end
        pmsm_pkg::ADR_OFS:
        begin
          adr_nxt = {reg_wdata[pmsm_pkg::ADR_PHY_LSB+4:pmsm_pkg::ADR_PHY_LSB],
                     reg_wdata[pmsm_pkg::ADR_REG_LSB+4:pmsm_pkg::ADR_REG_LSB]};
        end
        pmsm_pkg::WTD_OFS:
        begin
          wtd_nxt = reg_wdata[15:0];
          trig    = 1'b1;
          req_nxt = '{rd: 1'b0, phy: adr_r[9:5], reg_addr_field: adr_r[4:0],
                      data: reg_wdata[15:0]};
        end
        default:
        begin
          cfg_nxt = cfg_r;
        end
      endcase
    end
    pipe_nxt = {pipe_r[0], trig};
    if (reg_rd)
    begin
      case (reg_addr)
        pmsm_pkg::CFG_OFS: rdat_nxt = {26'h000_0000, cfg_r};
        pmsm_pkg::CMD_OFS: rdat_nxt = {30'h0000_0000, cmd_r};
        pmsm_pkg::ADR_OFS: rdat_nxt = {19'h0_0000, adr_r[9:5], 3'h0,
                                       adr_r[4:0]};
        pmsm_pkg::WTD_OFS: rdat_nxt = {16'h0000, wtd_r};
        pmsm_pkg::RDD_OFS: rdat_nxt = {16'h0000, rdd_r};
        pmsm_pkg::IND_OFS: rdat_nxt = {29'h0000_0000, nv_r, 1'b0, busy_r};
        default:           rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      cfg_r  <= pmsm_pkg::CFG_RST;
      cmd_r  <= pmsm_pkg::CMD_RST;
      adr_r  <= pmsm_pkg::ADR_RST;
      wtd_r  <= pmsm_pkg::DATA_RST;
      pipe_r <= 2'h0;
      req_r  <= '0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      cfg_r  <= cfg_nxt;
      cmd_r  <= cmd_nxt;
      adr_r  <= adr_nxt;
      wtd_r  <= wtd_nxt;
      pipe_r <= pipe_nxt;
      req_r  <= req_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Frame engine
  // ------------------------------------------------------------------
  // The frame is a fixed 64-bit vector; a bit is picked by its position.
  // fixed field order
  function automatic logic frame_bit(input pmsm_pkg::pmsm_req_t q,
                                     input logic [5:0] p);
    logic [63:0] v;
    v = {pmsm_pkg::PRE_PAT, pmsm_pkg::START_PAT,
         q.rd ? pmsm_pkg::OP_READ : pmsm_pkg::OP_WRITE,
         q.phy, q.reg_addr_field, pmsm_pkg::TA_WRITE, q.data};
    return v[pmsm_pkg::POS_LAST - p];
  endfunction

  function automatic logic frame_oe(input pmsm_pkg::pmsm_req_t q,
                                    input logic [5:0] p);
    return !(q.rd && (p >= pmsm_pkg::POS_TA));
  endfunction

  // half period is 2*(select+2) system cycles
  assign half_m1   = {1'b0, cfg_r[5:2], 1'b0} + pmsm_pkg::HALF_BASE_M1;
  assign tick      = (state_r == pmsm_pkg::ST_RUN) && (cnt_r == half_m1);
  assign frame_end = tick && mdc_r && (pos_r == pmsm_pkg::POS_LAST);

  always_comb
  begin
    state_nxt = state_r;
    cur_nxt   = cur_r;
    pos_nxt   = pos_r;
    cnt_nxt   = cnt_r;
    mdc_nxt   = mdc_r;
    mo_nxt    = mo_r;
    oe_nxt    = oe_r;
    rx_nxt    = rx_r;
    rdd_nxt   = rdd_r;
    busy_nxt  = busy_r;
    nv_nxt    = nv_r;
    case (state_r)
      pmsm_pkg::ST_IDLE:
      begin
        // busy follows the start three cycles on
        if (pipe_r[1])
        begin
          busy_nxt  = 1'b1;
          state_nxt = pmsm_pkg::ST_RUN;
          cur_nxt   = req_r;
          pos_nxt   = pos_first;
          cnt_nxt   = 6'h00;
          mdc_nxt   = 1'b0;
          mo_nxt    = frame_bit(req_r, pos_first);
          oe_nxt    = frame_oe(req_r, pos_first);
        end
      end
      pmsm_pkg::ST_RUN:
      begin
        cnt_nxt = tick ? 6'h00 : cnt_r + 6'h01;
        if (tick)
        begin
          // clock toggles only during a frame
          mdc_nxt = !mdc_r;
          if (!mdc_r)
          begin
            // PHY data sampled on the rising edge
            if (cur_r.rd && (pos_r >= pmsm_pkg::POS_DATA))
            begin
              rx_nxt = {rx_r[14:0], mdio_i};
            end
          end
          else if (pos_r != pmsm_pkg::POS_LAST)
          begin
            // next bit driven on the falling edge
            pos_nxt = pos_r + 6'h01;
            mo_nxt  = frame_bit(cur_r, pos_r + 6'h01);
            oe_nxt  = frame_oe(cur_r, pos_r + 6'h01);
          end
          else
          begin
            // store received word at frame end
            if (cur_r.rd)
            begin
              rdd_nxt = rx_r;
              if (cmd_r[pmsm_pkg::CMD_SCAN_BIT])
              begin
                nv_nxt = 1'b0;
              end
            end
            if (cmd_r[pmsm_pkg::CMD_SCAN_BIT])
            begin
              cur_nxt = scan_req;
              pos_nxt = pos_first;
              mo_nxt  = frame_bit(scan_req, pos_first);
              oe_nxt  = frame_oe(scan_req, pos_first);
            end
            else
            begin
              state_nxt = pmsm_pkg::ST_IDLE;
              busy_nxt  = 1'b0;
              mo_nxt    = 1'b0;
              oe_nxt    = 1'b0;
            end
          end
        end
      end
      default:
      begin
        state_nxt = pmsm_pkg::ST_IDLE;
      end
    endcase
    if (trig_scan)
    begin
      nv_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state_r <= pmsm_pkg::ST_IDLE;
      cur_r   <= '0;
      pos_r   <= pmsm_pkg::POS_FULL;
      cnt_r   <= 6'h00;
      mdc_r   <= 1'b0;
      mo_r    <= 1'b0;
      oe_r    <= 1'b0;
      rx_r    <= pmsm_pkg::DATA_RST;
      rdd_r   <= pmsm_pkg::DATA_RST;
      busy_r  <= 1'b0;
      nv_r    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cur_r   <= cur_nxt;
      pos_r   <= pos_nxt;
      cnt_r   <= cnt_nxt;
      mdc_r   <= mdc_nxt;
      mo_r    <= mo_nxt;
      oe_r    <= oe_nxt;
      rx_r    <= rx_nxt;
      rdd_r   <= rdd_nxt;
      busy_r  <= busy_nxt;
      nv_r    <= nv_nxt;
    end
  end

  assign reg_rdata = rdat_r;
  assign mdc       = mdc_r;
  assign mdio_o    = mo_r;
  assign mdio_oe   = oe_r;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  logic run;
  assign run = (state_r == pmsm_pkg::ST_RUN);

  sequence s_frame_end;
    frame_end;
  endsequence

  sequence s_rise;
    tick && !mdc_r;
  endsequence

  a_busy_delay: assert property (trig && !busy_r && !run |-> ##3 busy_r)
    else $error("busy not set three cycles after a start");

  a_idle_release: assert property (!run |-> !oe_r && !mdc_r)
    else $error("line driven or clock moving while idle");

  a_read_release: assert property (
    run && cur_r.rd && pos_r >= pmsm_pkg::POS_TA |-> !oe_r)
    else $error("read frame drives line after turnaround");

  a_edge_stable: assert property (s_rise |=> mdc_r && $stable(mo_r))
    else $error("data changed at the rising clock edge");

  a_preamble_ones: assert property (
    run && pos_r < pmsm_pkg::POS_START |-> mo_r && oe_r)
    else $error("preamble bit not a driven one");

  a_start_field: assert property (
    run && pos_r == pmsm_pkg::POS_START |-> !mo_r && oe_r)
    else $error("start pattern first bit not zero");

  a_preamble_suppress_skip: assert property (
    !run && pipe_r[1] && preamble_suppress |=> pos_r == pmsm_pkg::POS_PREAMBLE_SUPPRESS)
    else $error("suppressed frame did not skip the preamble");

  a_busy_clear: assert property (
    s_frame_end ##0 !cmd_r[pmsm_pkg::CMD_SCAN_BIT] |=> !busy_r ##1 !run)
    else $error("busy still set after the last frame");

  a_nv_clear: assert property (
    s_frame_end ##0 cmd_r[pmsm_pkg::CMD_SCAN_BIT] |=> !nv_r && busy_r)
    else $error("not-valid kept after a scan read");

  a_read_store: assert property (
    s_frame_end ##0 cur_r.rd |=> rdd_r == $past(rx_r))
    else $error("read data not stored at frame end");

endmodule

/* test/pmsm_phy_model.sv */
// Behavioural management-port partner used by the serial master bench.
`timescale 1ns/1ps

module pmsm_phy_model
#(
  parameter logic [4:0] OWN_ADDR = 5'h11
)
(
  input  wire logic           mdc,
  input  wire logic           mdio_o,
  input  wire logic           mdio_oe,
  output logic                mdio_i,
  output pmsm_pkg::pmsm_req_t fr,
  output logic [12:0]         fr_aux,
  output int                  frames,
  output int                  clashes
);
  logic [15:0] mem [32];
  logic [12:0] hdr;
  logic [17:0] sh;
  logic [15:0] rdv;
  logic [7:0]  ones = 8'h00;
  logic        phy_oe = 1'b0;
  logic        phy_o = 1'b0;
  logic        hit = 1'b0;
  logic        rd_me = 1'b0;
  int          cnt = -1;

  initial
  begin
    for (int i = 0; i < 32; i++)
      mem[i] = 16'h0000;
  end

  assign mdio_i = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);

  always @(posedge mdc)
  begin
    if (mdio_oe && phy_oe)
      clashes++;
    if (cnt < 0)
    begin
      if (mdio_oe && mdio_i)
        ones++;
      else if (mdio_oe)
        cnt = 0;
    end
    else
    begin
      cnt++;
      if (cnt <= 13)
        hdr = {hdr[11:0], mdio_i};
      else
        sh = {sh[16:0], mdio_i};
      if (cnt == 13)
      begin
        hit = hdr[9:5] == OWN_ADDR || hdr[9:5] == 5'h00;
        rd_me = hit && hdr[11:10] == 2'b10;
        rdv = mem[hdr[4:0]];
      end
      if (cnt == 31)
      begin
        if (hit && hdr[11:10] == 2'b01 && hdr[4:0] < 5'h08)
          mem[hdr[4:0]] = sh[15:0];
        fr = {hdr[11:10] == 2'b10, hdr[9:0], sh[15:0]};
        fr_aux = {ones, hdr[12:10], sh[17:16]};
        ones = 8'h00;
        cnt = -1;
        rd_me = 1'b0;
        frames++;
      end
    end
  end

  always @(negedge mdc)
  begin
    phy_oe = rd_me && cnt >= 14;
    if (cnt == 14)
      phy_o = 1'b0;
    else if (cnt > 14 && cnt <= 30)
      phy_o = rdv[30 - cnt];
  end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the management serial master.
`timescale 1ns/1ps

module tb_top;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_d = 1'b0;
  logic [31:0] reg_rdata, last, v, seed = 32'h0000_D29C;
  logic        mdc, mdio_i, mdio_o, mdio_oe;
  logic [12:0] fr_aux;
  logic [32:0] e;
  logic [39:0] f;
  logic [32:0] rq[$];
  logic [39:0] fq[$];
  logic [15:0] ex [6];
  logic [4:0]  pa [6] = '{5'h11, 5'h11, 5'h11, 5'h00, 5'h03, 5'h11};
  logic [4:0]  ra [6] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h01, 5'h14};
  pmsm_pkg::pmsm_req_t fr;
  int          frames, clashes, base, mismatches = 0, tests_run = 0;
  int          cyc = 0;
  time         t;

  always #5 clk_sys = ~clk_sys;

  pmsm_master dut_u
  (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .mdc       (mdc),
    .mdio_i    (mdio_i),
    .mdio_o    (mdio_o),
    .mdio_oe   (mdio_oe)
  );

  pmsm_phy_model #(.OWN_ADDR(5'h11)) phy_u
  (
    .mdc     (mdc),
    .mdio_o  (mdio_o),
    .mdio_oe (mdio_oe),
    .mdio_i  (mdio_i),
    .fr      (fr),
    .fr_aux  (fr_aux),
    .frames  (frames),
    .clashes (clashes)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(string nm, logic [39:0] seen, logic [39:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] x, logic c = 1'b1);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    rq.push_back({c, x});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  // A start followed by indicator reads in the three cycles after it.
  task automatic go(logic [7:0] a, logic [31:0] d, logic [31:0] nv);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    for (int k = 1; k <= 3; k++)
    begin
      @(posedge clk_sys);
      reg_wr   <= 1'b0;
      reg_rd   <= 1'b1;
      reg_addr <= pmsm_pkg::IND_OFS;
      rq.push_back({1'b1, nv | {31'h0, k == 3}});
    end
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  // poll busy before any new start
  task automatic idle_wait();
    v = 32'h1;
    for (int i = 0; i < 3000 && v[0] !== 1'b0; i++)
    begin
      rd(pmsm_pkg::IND_OFS, 32'h0, 1'b0);
      @(posedge clk_sys);
      #1 v = last;
    end
    chk("busy", v[0], 1'b0);
    chk("mdio_oe", mdio_oe, 1'b0);
    chk("mdc_idle", mdc, 1'b0);
  endtask

  task automatic note(logic [7:0] p, logic [1:0] op, logic [9:0] a,
                      logic [15:0] d);
    logic [1:0] ta;
    // an unanswered read sees the pull-up in both turnaround bits.
    ta = (op == 2'b10 && a[9:5] != 5'h11 && a[9:5] != 5'h00) ? 2'b11 : 2'b10;
    fq.push_back({p, 1'b1, op, ta, op == 2'b10, a, d});
  endtask

  task automatic wait_fr(int n);
    for (int i = 0; i < 3000 && frames < n; i++)
      @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 40000)
    begin
      mismatches++;
      test_done();
    end
    else
    begin
      if (rd_d)
      begin
        e = rq.pop_front();
        last = reg_rdata;
        if (e[32])
          chk("rdata", reg_rdata, e[31:0]);
      end
      rd_d <= reg_rd;
    end
  end

  always @(frames)
  begin
    // The frame fields reach this side through separate ports; let them settle.
    #1 f = fq.pop_front();
    chk("preamble", fr_aux[12:5], f[39:32]);
    chk("start_op", fr_aux[4:2], f[31:29]);
    chk("turnaround", fr_aux[1:0], f[28:27]);
    chk("fields", fr, f[26:0]);
  end

  initial
  begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int a = 0; a <= 24; a += 4)
      rd(a[7:0], 32'h0);
    wr(8'h18, 32'hFFFF_FFFF);
    rd(8'h18, 32'h0);
    wr(pmsm_pkg::ADR_OFS, 32'hFFFF_FFFF);
    rd(pmsm_pkg::ADR_OFS, 32'h0000_1F1F);
    wr(pmsm_pkg::RDD_OFS, xs());
    rd(pmsm_pkg::RDD_OFS, 32'h0);
    wr(pmsm_pkg::CFG_OFS, 32'h0000_003E);
    rd(pmsm_pkg::CFG_OFS, 32'h0000_003E);
    $display("test registers done");
    for (int s = 0; s < 3; s++)
    begin
      ex[s] = 16'(xs());
      wr(pmsm_pkg::CFG_OFS, s << 2);
      wr(pmsm_pkg::ADR_OFS, {24'h11, 3'h0, s[4:0]});
      note(8'h20, 2'b01, {5'h11, s[4:0]}, ex[s]);
      go(pmsm_pkg::WTD_OFS, {16'h0, ex[s]}, 32'h0);
      @(posedge mdc) t = $time;
      @(posedge mdc) chk("mdc_period", 40'(($time - t) / 10), 4 * (s + 2));
      idle_wait();
    end
    $display("test writes done");
    ex[3] = 16'(xs());
    ex[4] = 16'hFFFF;
    ex[5] = 16'h0000;
    phy_u.mem[5] = ex[3];
    wr(pmsm_pkg::CFG_OFS, 32'h0);
    for (int j = 0; j < 6; j++)
    begin
      if (j == 3)
        wr(pmsm_pkg::CFG_OFS, 32'h2);
      wr(pmsm_pkg::ADR_OFS, {19'h0, pa[j], 3'h0, ra[j]});
      note(j < 3 ? 8'h20 : 8'h00, 2'b10, {pa[j], ra[j]}, ex[j]);
      go(pmsm_pkg::CMD_OFS, 32'h1, 32'h0);
      idle_wait();
      wr(pmsm_pkg::CMD_OFS, 32'h0);
      rd(pmsm_pkg::RDD_OFS, {16'h0, ex[j]});
    end
    $display("test reads done");
    ex[0] = 16'(xs());
    ex[1] = 16'(xs());
    phy_u.mem[4] = ex[0];
    base = frames;
    wr(pmsm_pkg::CFG_OFS, 32'h0);
    wr(pmsm_pkg::ADR_OFS, 32'h0000_1104);
    note(8'h20, 2'b10, 10'h224, ex[0]);
    go(pmsm_pkg::CMD_OFS, 32'h2, 32'h4);
    wait_fr(base + 1);
    phy_u.mem[4] = ex[1];
    note(8'h20, 2'b10, 10'h224, ex[1]);
    note(8'h20, 2'b10, 10'h224, ex[1]);
    rd(pmsm_pkg::IND_OFS, 32'h1);
    rd(pmsm_pkg::RDD_OFS, {16'h0, ex[0]});
    wait_fr(base + 2);
    rd(pmsm_pkg::RDD_OFS, {16'h0, ex[1]});
    wr(pmsm_pkg::CMD_OFS, 32'h0);
    rd(pmsm_pkg::IND_OFS, 32'h1);
    idle_wait();
    chk("scan_frames", 40'(frames - base), 40'h3);
    chk("left_notes", 40'(fq.size()), 40'h0);
    chk("clashes", 40'(clashes), 40'h0);
    $display("test scan done");
    test_done();
  end
endmodule
